// file: serial_pkg.sv
package serial_pkg;
   // register offsets; only the data port offset is given, the other two are chosen
   localparam logic [7:0] DATA_OFFSET   = 8'h46;
   localparam logic [7:0] CTRL_OFFSET   = 8'h44;
   localparam logic [7:0] STATUS_OFFSET = 8'h45;
   // control register fields
   localparam int CTRL_RX_IE   = 7;
   localparam int CTRL_DMA_SEL = 6;
   localparam int CTRL_MASTER  = 5;
   localparam int CTRL_IDLE    = 4;
   localparam int CTRL_PHASE   = 3;
   localparam int CTRL_OD      = 2;
   localparam int CTRL_ENABLE  = 1;
   localparam int CTRL_TX_IE   = 0;
   // status and control register fields
   localparam int STAT_RXF     = 7;
   localparam int STAT_ERR_IE  = 6;
   localparam int STAT_OVR     = 5;
   localparam int STAT_MODE_FAULT_FLAG    = 4;
   localparam int STAT_TXE     = 3;
   localparam int STAT_MODE_FAULT_FLAG_EN = 2;
   localparam int STAT_RATE_HI = 1;
   localparam int STAT_RATE_LO = 0;
   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h28;
   localparam logic [3:0] STAT_W_RESET = 4'h0;
   // half-period counts in generator cycles per rate code (divisor 2,8,32,128)
   localparam logic [7:0] HALF_DIV0 = 8'h02;
   localparam logic [7:0] HALF_DIV1 = 8'h08;
   localparam logic [7:0] HALF_DIV2 = 8'h20;
   localparam logic [7:0] HALF_DIV3 = 8'h80;
   localparam logic [2:0] BITS_LAST = 3'h7;
endpackage

// file: serial_ctrl.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - rx and tx interrupt requests gated by their enables; enables reset low.
// - master select chooses master when set; resets to master.
// - clock idle level sets serial clock level between bytes; resets low.
// - clock phase selects clock/data timing; resets to one.
// - phase-zero slave starts on select fall, drives msb, locks shift register.
// - phase-one slave starts transfer on first serial clock edge.
// - deselected slave floats miso, ignores clocks, keeps its state.
// - open-drain select makes clock, mosi, miso open-drain.
// - module enable runs interface; clearing it partially resets; resets low.
// - rx full sets on byte to receive register; cleared status-then-data read.
// - error interrupt enable gates overflow and mode fault requests.
// - overflow sets on byte while rx full; old byte kept, new lost.
// - overflow clears by status read with flag set then data read.
// - mode fault: slave select rises mid-transfer (slave), falls (master).
// - mode fault clears by status read then control write, not by enable.
// - tx empty sets when transmit register hands byte to shifter; resets high.
// - idle shifter loads within two cycles; active slave loads after byte.
// - master with detection off ignores select; slave always uses it.
// - rate bits pick divisor 2,8,32,128; clock is generator over twice that.
// - data writes go to transmit register, reads from separate receive one.
module serial_ctrl
   import serial_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       clock_generator_output,
   // register port
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rdata,
   // serial pins
   input  wire logic       sck_in,
   output logic            sck_out,
   output logic            sck_oe,
   input  wire logic       mosi_in,
   output logic            mosi_out,
   output logic            mosi_oe,
   input  wire logic       miso_in,
   output logic            miso_out,
   output logic            miso_oe,
   input  wire logic       ss_n_in,
   // requests
   output logic            cpu_irq,
   output logic            dma_service_select
);
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {IDLE = 2'b00, RUN = 2'b01, DONE = 2'b10} xfer_e;
   xfer_e       state_reg;
   logic [7:0]  ctrl_reg, tx_reg, rx_reg, shift_reg, rdata_reg, div_reg;
   logic [3:0]  statw_reg;
   logic        rxf_reg, ovr_reg, mode_fault_flag_reg, txe_reg, txfull_reg;
   logic        arm_rx_reg, arm_mode_fault_flag_reg;
   logic [2:0]  bit_reg;
   logic        sck_reg;
   logic [2:0]  ss_sync, sck_sync, mosi_sync, miso_sync, gen_sync;
   logic        irq_reg;

   // pins cross in through two flops; the third stage is only for edges
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ss_sync   <= 3'h7;
         sck_sync  <= 3'h0;
         mosi_sync <= 3'h0;
         miso_sync <= 3'h0;
         gen_sync  <= 3'h0;
      end else begin
         ss_sync   <= {ss_sync[1:0], ss_n_in};
         sck_sync  <= {sck_sync[1:0], sck_in};
         mosi_sync <= {mosi_sync[1:0], mosi_in};
         miso_sync <= {miso_sync[1:0], miso_in};
         gen_sync  <= {gen_sync[1:0], clock_generator_output};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   wire enable    = ctrl_reg[CTRL_ENABLE];
   wire master    = ctrl_reg[CTRL_MASTER];
   wire clock_idle_level      = ctrl_reg[CTRL_IDLE];
   wire clock_phase_select      = ctrl_reg[CTRL_PHASE];
   wire mode_fault_flag_en   = statw_reg[STAT_MODE_FAULT_FLAG_EN];
   // error enable sits in the top bit of the stored status half
   wire err_ie    = statw_reg[3];
   wire ss_n      = ss_sync[1];
   wire ss_fall   = ss_sync[2] & ~ss_sync[1];
   wire ss_rise   = ~ss_sync[2] & ss_sync[1];
   wire sck_s     = sck_sync[1];
   wire sck_edge  = sck_sync[2] ^ sck_sync[1];
   wire gen_tick  = gen_sync[1] & ~gen_sync[2];
   wire wr_data   = wr_en & (addr == DATA_OFFSET);
   wire wr_ctrl   = wr_en & (addr == CTRL_OFFSET);
   wire wr_stat   = wr_en & (addr == STATUS_OFFSET);
   wire rd_data   = rd_en & (addr == DATA_OFFSET);
   wire rd_stat   = rd_en & (addr == STATUS_OFFSET);
   wire slave_on  = enable & ~master & ~ss_n;
   wire [7:0] half_div = (statw_reg[1:0] == 2'b00) ? HALF_DIV0 :
                         (statw_reg[1:0] == 2'b01) ? HALF_DIV1 :
                         (statw_reg[1:0] == 2'b10) ? HALF_DIV2 : HALF_DIV3;
   // master clock edge: half period of serial clock elapsed
   wire m_edge    = enable & master & (state_reg == RUN) & gen_tick
                    & (div_reg == half_div - 8'h01);
   // slave edge: only honoured while selected
   wire s_edge    = slave_on & sck_edge & (state_reg == RUN);
   wire step      = m_edge | s_edge;
   // leading edge samples when phase zero, trailing edge when phase one
   wire lead      = master ? (sck_reg == clock_idle_level) : (sck_s != clock_idle_level);
   wire sample    = step & (lead ^ clock_phase_select);
   wire shift_out = step & ~(lead ^ clock_phase_select);
   wire byte_done = sample & (bit_reg == BITS_LAST);
   wire in_bit    = master ? miso_sync[1] : mosi_sync[1];
   wire start_m   = enable & master & (state_reg == IDLE) & txfull_reg;
   wire start_s0  = enable & ~master & ~clock_phase_select & ss_fall & (state_reg == IDLE);
   wire start_s1  = slave_on & clock_phase_select & sck_edge & (state_reg == IDLE);
   wire load_now  = (state_reg == IDLE) & txfull_reg & ~(enable & ~master & ~ss_n & ~clock_phase_select);
   wire mode_fault_flag_set  = mode_fault_flag_en & enable &
                    ((master & ss_fall) | (~master & ss_rise & (state_reg == RUN)));
   wire irq_next  = (rxf_reg & ctrl_reg[CTRL_RX_IE])
                    | (txe_reg & ctrl_reg[CTRL_TX_IE])
                    | ((ovr_reg | mode_fault_flag_reg) & err_ie);
   wire [7:0] stat_view = {rxf_reg, statw_reg[3], ovr_reg, mode_fault_flag_reg,
                           txe_reg, statw_reg[2:0]};
   wire [7:0] rd_next = rd_data ? rx_reg :
                        rd_stat ? stat_view :
                        (rd_en & (addr == CTRL_OFFSET)) ? ctrl_reg : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // registers written by software
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg  <= CTRL_RESET;
         statw_reg <= STAT_W_RESET;
         tx_reg    <= 8'h00;
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rd_en ? rd_next : 8'h00;
         if (wr_ctrl)
            ctrl_reg <= wdata;
         if (wr_stat)
            statw_reg <= {wdata[STAT_ERR_IE], wdata[2:0]};
         if (wr_data)
            tx_reg <= wdata;
      end
   end

   // flags; every set except overflow and tx full wins over a same-cycle clear; a clearing data read blocks the overflow set
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rxf_reg <= 1'b0;
         ovr_reg <= 1'b0;
         mode_fault_flag_reg <= 1'b0;
         txe_reg <= 1'b1;
         txfull_reg <= 1'b0;
         arm_rx_reg <= 1'b0;
         arm_mode_fault_flag_reg <= 1'b0;
         rx_reg <= 8'h00;
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
         if (rd_stat)
            arm_rx_reg <= rxf_reg | ovr_reg;
         else if (rd_data)
            arm_rx_reg <= 1'b0;
         if (rd_stat)
            arm_mode_fault_flag_reg <= mode_fault_flag_reg;
         else if (wr_ctrl)
            arm_mode_fault_flag_reg <= 1'b0;
         if (byte_done & (~rxf_reg | (rd_data & arm_rx_reg))) begin
            rxf_reg <= 1'b1;
            rx_reg <= {shift_reg[6:0], in_bit};
         end else if (rd_data & arm_rx_reg)
            rxf_reg <= 1'b0;
         if (byte_done & rxf_reg & ~(rd_data & arm_rx_reg))
            ovr_reg <= 1'b1;
         else if (rd_data & arm_rx_reg)
            ovr_reg <= 1'b0;
         if (mode_fault_flag_set)
            mode_fault_flag_reg <= 1'b1;
         else if (wr_ctrl & arm_mode_fault_flag_reg)
            mode_fault_flag_reg <= 1'b0;
         if (load_now & (enable | txfull_reg)) begin
            txe_reg <= 1'b1;
            txfull_reg <= 1'b0;
         end else if (wr_data) begin
            txe_reg <= 1'b0;
            txfull_reg <= 1'b1;
         end
         if (!enable)
            txe_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shifter and transfer sequencing
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= IDLE;
         shift_reg <= 8'h00;
         bit_reg   <= 3'h0;
         div_reg   <= 8'h00;
         sck_reg   <= 1'b0;
      end else if (!enable) begin
         state_reg <= IDLE;
         bit_reg   <= 3'h0;
         div_reg   <= 8'h00;
         sck_reg   <= clock_idle_level;
      end else begin
         if (load_now)
            shift_reg <= tx_reg;
         if (state_reg == IDLE)
            sck_reg <= clock_idle_level;
         if (gen_tick & master & (state_reg == RUN))
            div_reg <= (div_reg == half_div - 8'h01) ? 8'h00 : div_reg + 8'h01;
         if (m_edge)
            sck_reg <= ~sck_reg;
         if (sample) begin
            shift_reg <= {shift_reg[6:0], in_bit};
            bit_reg   <= bit_reg + 3'h1;
         end
         unique case (state_reg)
            IDLE: begin
               if (start_m | start_s0 | start_s1)
                  state_reg <= RUN;
            end
            RUN: begin
               if (byte_done)
                  state_reg <= DONE;
            end
            DONE: begin
               // master parks clock; slave waits for select or next edge
               if (master | ss_n | clock_phase_select)
                  state_reg <= IDLE;
            end
            default: state_reg <= IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive; open-drain only ever drives low
   logic data_bit_reg, sck_q, mosi_oe_q, miso_oe_q, sck_oe_q, dma_q;
   wire  od = ctrl_reg[CTRL_OD];
   wire  msb = shift_reg[7];
   // data moves only on shift edges or while idle so the far side samples a settled bit
   wire  out_next = ((state_reg == IDLE) | shift_out) ? msb : data_bit_reg;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         data_bit_reg <= 1'b0;
         sck_q <= 1'b0;
         sck_oe_q <= 1'b0;
         mosi_oe_q <= 1'b0;
         miso_oe_q <= 1'b0;
         dma_q <= 1'b0;
      end else begin
         data_bit_reg <= out_next;
         sck_q <= sck_reg;
         dma_q <= ctrl_reg[CTRL_DMA_SEL];
         sck_oe_q  <= enable & master & (~od | ~sck_reg);
         mosi_oe_q <= enable & master & (~od | ~out_next);
         miso_oe_q <= slave_on & (~od | ~out_next);
      end
   end

   assign rdata    = rdata_reg;
   assign sck_out  = sck_q;
   assign sck_oe   = sck_oe_q;
   assign mosi_out = data_bit_reg;
   assign mosi_oe  = mosi_oe_q;
   assign miso_out = data_bit_reg;
   assign miso_oe  = miso_oe_q;
   assign cpu_irq  = irq_reg;
   assign dma_service_select = dma_q;

   ////////////////////////////////////////////////////////////////////////////
   property p_ctrl_reset;
      @(posedge sys_clk) $rose(resetn) |-> ctrl_reg == CTRL_RESET;
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset) else $error("ctrl reset");

   property p_irq_gate;
      @(posedge sys_clk) disable iff (!resetn)
      (rxf_reg & ctrl_reg[CTRL_RX_IE]) |=> cpu_irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("rx irq missing");

   property p_err_gate;
      @(posedge sys_clk) disable iff (!resetn)
      (~irq_next) |=> ~cpu_irq;
   endproperty
   a_err_gate: assert property (p_err_gate) else $error("spurious irq");

   property p_ovr_keep;
      @(posedge sys_clk) disable iff (!resetn)
      (byte_done & rxf_reg & ~(rd_data & arm_rx_reg)) |=> $stable(rx_reg) && ovr_reg;
   endproperty
   a_ovr_keep: assert property (p_ovr_keep) else $error("overflow");

   property p_rx_clear;
      @(posedge sys_clk) disable iff (!resetn)
      (rd_data & arm_rx_reg & ~byte_done) |=> ~rxf_reg && ~ovr_reg;
   endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("rx clear");

   property p_mode_fault_flag_hold;
      @(posedge sys_clk) disable iff (!resetn)
      (mode_fault_flag_reg & ~(wr_ctrl & arm_mode_fault_flag_reg)) |=> mode_fault_flag_reg;
   endproperty
   a_mode_fault_flag_hold: assert property (p_mode_fault_flag_hold) else $error("mode_fault_flag lost");

   property p_miso_float;
      @(posedge sys_clk) disable iff (!resetn)
      ss_n ##1 ss_n |=> ~miso_oe;
   endproperty
   a_miso_float: assert property (p_miso_float) else $error("miso driven");

   property p_disable;
      @(posedge sys_clk) disable iff (!resetn)
      ~enable |=> state_reg == IDLE && txe_reg;
   endproperty
   a_disable: assert property (p_disable) else $error("partial reset");

   property p_txe_reset;
      @(posedge sys_clk) $rose(resetn) |-> txe_reg;
   endproperty
   a_txe_reset: assert property (p_txe_reset) else $error("txe reset");

   property p_arm_rx;
      @(posedge sys_clk) disable iff (!resetn)
      (rd_stat & (rxf_reg | ovr_reg)) |=> arm_rx_reg;
   endproperty
   a_arm_rx: assert property (p_arm_rx) else $error("rx clear not armed");

   sequence s_byte_in;
      byte_done & ~rxf_reg;
   endsequence
   property p_rx_load;
      @(posedge sys_clk) disable iff (!resetn)
      s_byte_in |=> rxf_reg;
   endproperty
   a_rx_load: assert property (p_rx_load) else $error("rx full not set");

   sequence s_idle_write;
      wr_data & enable & master & (state_reg == IDLE) & ~txfull_reg;
   endsequence
   property p_txe_load;
      @(posedge sys_clk) disable iff (!resetn)
      s_idle_write |-> ##[1:2] txe_reg;
   endproperty
   a_txe_load: assert property (p_txe_load) else $error("txe not back");

   property p_sck_idle;
      @(posedge sys_clk) disable iff (!resetn)
      (enable & master & (state_reg == IDLE)) |=> sck_reg == $past(clock_idle_level);
   endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("sck idle level");

   property p_mode_fault_flag_master;
      @(posedge sys_clk) disable iff (!resetn)
      (mode_fault_flag_en & enable & master & ss_fall) |=> mode_fault_flag_reg;
   endproperty
   a_mode_fault_flag_master: assert property (p_mode_fault_flag_master) else $error("mode_fault_flag master");

   property p_od_drive;
      @(posedge sys_clk) disable iff (!resetn)
      $past(od) |-> ~(sck_oe & sck_out) && ~(mosi_oe & mosi_out);
   endproperty
   a_od_drive: assert property (p_od_drive) else $error("od drives high");

   property p_rate_edge;
      @(posedge sys_clk) disable iff (!resetn)
      m_edge |=> sck_reg != $past(sck_reg);
   endproperty
   a_rate_edge: assert property (p_rate_edge) else $error("sck edge");
endmodule
`default_nettype wire

// file: serial_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_slave_model (
   // pins
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       ss_n,
   output logic            miso,
   output logic            miso_oe,
   // setup and result
   input  wire logic       clock_idle_level,
   input  wire logic       clock_phase_select,
   input  wire logic [7:0] tx_byte,
   output logic      [7:0] rx_byte,
   output int              nbits
);
   logic [7:0] sh;
   initial begin
      miso = 1'b0;
      miso_oe = 1'b0;
      rx_byte = 8'h00;
      nbits = 0;
      sh = 8'h00;
   end
   task automatic push();
      miso_oe = 1'b1;
      miso = sh[7];
      sh = {sh[6:0], 1'b0};
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // released miso falls back to the pull-up on the wire
   always @(ss_n) begin
      if (!ss_n) begin
         sh = tx_byte;
         nbits = 0;
         if (!clock_phase_select) push();
      end else begin
         miso_oe = 1'b0;
      end
   end
   // sample on the edge that the phase picks, shift out on the other
   always @(sck) begin
      if (!ss_n) begin
         if ((sck != clock_idle_level) ^ clock_phase_select) begin
            rx_byte = {rx_byte[6:0], mosi};
            nbits++;
         end else begin
            push();
         end
      end
   end
endmodule
`default_nettype wire

// file: spi_control_status_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module spi_control_status_regs_tb_top;
   import serial_pkg::*;
   logic       sys_clk, resetn, gen, wr_en, rd_en, ss_pin, ss_sel, od;
   logic [7:0] addr, wdata, rdata, stx, rx_byte;
   logic       sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
   logic       m_miso, m_oe, cpu_irq, dma_sel;
   wire        sck_w, mosi_w, miso_w;
   int         nbits, num_errors, samples_checked, cycles, hi_cnt, hi_len, od_bad, pp_hi;
   // undriven lines show the pull-up level
   assign sck_w  = sck_oe ? sck_out : 1'b1;
   assign mosi_w = mosi_oe ? mosi_out : 1'b1;
   assign miso_w = m_oe ? m_miso : 1'b1;
   serial_ctrl dut (.sys_clk(sys_clk), .resetn(resetn), .clock_generator_output(gen),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
      .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
      .miso_oe(miso_oe), .ss_n_in(ss_pin), .cpu_irq(cpu_irq), .dma_service_select(dma_sel));
   serial_slave_model peer (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_sel), .miso(m_miso),
      .miso_oe(m_oe), .clock_idle_level(1'b0), .clock_phase_select(1'b1), .tx_byte(stx), .rx_byte(rx_byte),
      .nbits(nbits));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // generator rises every fourth bus cycle
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles % 2 == 1) gen <= ~gen;
      if (sck_w) hi_cnt <= hi_cnt + 1;
      else begin
         if (hi_cnt != 0) hi_len <= hi_cnt;
         hi_cnt <= 0;
      end
      if ((sck_oe && sck_out) || (mosi_oe && mosi_out)) begin
         if (od) od_bad <= od_bad + 1;
         else pp_hi <= pp_hi + 1;
      end
      if (cycles == 40000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask
   // one framed byte; select toggles between bytes as phase zero would need
   task automatic xfer(input logic [7:0] d, input logic [7:0] s, input bit chk);
      int n;
      logic [7:0] st;
      stx <= s;
      ss_sel <= 1'b0;
      wr(DATA_OFFSET, d);
      if (chk) begin
         rd(STATUS_OFFSET, st);
         `CHK("txe after write", 1'b1, st[STAT_TXE])
      end
      n = 0;
      while (nbits != 8 && n < 20000) begin
         @(posedge sys_clk);
         n++;
      end
      repeat (20) @(posedge sys_clk);
      ss_sel <= 1'b1;
      @(posedge sys_clk);
      `CHK("peer rx", d, rx_byte)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic s_reset();
      logic [7:0] v;
      rd(CTRL_OFFSET, v);
      `CHK("ctrl reset", CTRL_RESET, v)
      rd(STATUS_OFFSET, v);
      `CHK("status reset", 8'h08, v)
      rd(8'h40, v);
      `CHK("unmapped", 8'h00, v)
      `CHK("dma sel", 1'b0, dma_sel)
      wr(CTRL_OFFSET, 8'h69);
      repeat (3) @(posedge sys_clk);
      `CHK("tx irq on", 1'b1, cpu_irq)
      `CHK("dma sel on", 1'b1, dma_sel)
      wr(CTRL_OFFSET, 8'h28);
      repeat (3) @(posedge sys_clk);
      `CHK("tx irq off", 1'b0, cpu_irq)
   endtask
   task automatic s_rate();
      int c;
      logic [7:0] st, cb;
      wr(CTRL_OFFSET, 8'h2a);
      for (c = 0; c < 4; c++) begin
         cb = c[7:0];
         wr(STATUS_OFFSET, cb);
         xfer(8'h96 ^ cb, 8'h3c + cb, 1'b1);
         `CHK("sck half", 4 * (2 << (2 * c)), hi_len)
         rd(STATUS_OFFSET, st);
         `CHK("rx full set", 8'h88 | cb, st)
         rd(DATA_OFFSET, st);
         `CHK("rx data", 8'h3c + cb, st)
         rd(STATUS_OFFSET, st);
         `CHK("rx full clear", 8'h08 | cb, st)
      end
      wr(STATUS_OFFSET, 8'h00);
   endtask
   task automatic s_overflow();
      logic [7:0] v;
      xfer(8'h11, 8'hc1, 1'b0);
      xfer(8'h22, 8'hc2, 1'b0);
      `CHK("irq masked", 1'b0, cpu_irq)
      wr(CTRL_OFFSET, 8'haa);
      repeat (3) @(posedge sys_clk);
      `CHK("rx irq", 1'b1, cpu_irq)
      wr(CTRL_OFFSET, 8'h2a);
      wr(STATUS_OFFSET, 8'h40);
      repeat (3) @(posedge sys_clk);
      `CHK("err irq", 1'b1, cpu_irq)
      wr(STATUS_OFFSET, 8'h00);
      repeat (3) @(posedge sys_clk);
      `CHK("err irq off", 1'b0, cpu_irq)
      rd(DATA_OFFSET, v);
      `CHK("old byte kept", 8'hc1, v)
      rd(STATUS_OFFSET, v);
      `CHK("ovr held", 8'ha8, v)
      rd(DATA_OFFSET, v);
      rd(STATUS_OFFSET, v);
      `CHK("ovr cleared", 8'h08, v)
   endtask
   task automatic s_mode_fault_flag();
      logic [7:0] v;
      wr(STATUS_OFFSET, 8'h04);
      ss_pin <= 1'b0;
      repeat (6) @(posedge sys_clk);
      ss_pin <= 1'b1;
      rd(STATUS_OFFSET, v);
      `CHK("mode_fault_flag set", 8'h1c, v)
      wr(STATUS_OFFSET, 8'h00);
      rd(STATUS_OFFSET, v);
      `CHK("mode_fault_flag kept", 8'h18, v)
      wr(CTRL_OFFSET, 8'h2a);
      rd(STATUS_OFFSET, v);
      `CHK("mode_fault_flag cleared", 8'h08, v)
   endtask
   task automatic s_pins();
      logic [7:0] v;
      wr(CTRL_OFFSET, 8'h2e);
      repeat (4) @(posedge sys_clk);
      od <= 1'b1;
      xfer(8'h5c, 8'ha3, 1'b0);
      od <= 1'b0;
      `CHK("open drain high", 0, od_bad)
      `CHK("push pull high", 1'b1, pp_hi > 0)
      rd(STATUS_OFFSET, v);
      rd(DATA_OFFSET, v);
      `CHK("od rx", 8'ha3, v)
      wr(CTRL_OFFSET, 8'h3a);
      repeat (4) @(posedge sys_clk);
      `CHK("idle high", 1'b1, sck_out)
      wr(CTRL_OFFSET, 8'h2a);
      repeat (4) @(posedge sys_clk);
      `CHK("idle low", 1'b0, sck_out)
      wr(STATUS_OFFSET, 8'h03);
      ss_sel <= 1'b0;
      wr(DATA_OFFSET, 8'h77);
      repeat (600) @(posedge sys_clk);
      wr(CTRL_OFFSET, 8'h28);
      repeat (4) @(posedge sys_clk);
      ss_sel <= 1'b1;
      `CHK("off sck oe", 1'b0, sck_oe)
      `CHK("off mosi oe", 1'b0, mosi_oe)
      `CHK("master miso oe", 1'b0, miso_oe)
      rd(STATUS_OFFSET, v);
      `CHK("off txe", 1'b1, v[STAT_TXE])
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {resetn, gen, wr_en, rd_en, od} = '0;
      {ss_pin, ss_sel} = 2'b11;
      {addr, wdata, stx} = '0;
      {num_errors, samples_checked, cycles, hi_cnt, hi_len, od_bad, pp_hi} = '0;
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      s_reset();
      s_rate();
      s_overflow();
      s_mode_fault_flag();
      s_pins();
      report_and_stop();
   end
endmodule
`default_nettype wire
